// [opdec.sv]
`timescale 1ns/1ps
`include "opdec_cfg.svh"
module opdec (
   input wire logic ref_clk,
   input wire logic rst_b,
   input wire logic [7:0] opcode,
   input wire logic [7:0] opnd_hi,
   input wire logic [7:0] opnd_lo,
   input wire logic [15:0] pc_next,
   input wire logic [15:0] index_pair,
   input wire logic [15:0] sp_in,
   input wire logic [7:0] flags_in,
   input wire logic [7:0] vec_low,
   input wire logic vec_lo_phase,
   input wire logic push_req,
   input wire logic pop_req,
   input wire logic irq_pending,
   output logic [13:0] dec_out,
   output logic [15:0] sp_out,
   output logic sp_load,
   output logic [7:0] flags_out,
   output logic halted,
   output logic [15:0] ea_out,
   output logic [15:0] branch_target,
   output logic [15:0] literal_word,
   output logic [15:0] vec_addr,
   output logic [19:0] bus_req
);
   // Decode, address and control state registers.
   opdec_pkg::decode_type dec_q, dec_d;
   opdec_pkg::bus_req_type req_q, req_d;
   logic [15:0] sp_q, sp_d, ea_q, ea_d, br_q, br_d, lit_q, lit_d;
   logic [15:0] vec_q, vec_d;
   logic [7:0] flags_q, flags_d;
   logic sp_load_q, sp_load_d, halt_q, halt_d;
   logic [15:0] off_ext;

   // Table lookup; unknown opcodes report valid low so the sequencer can trap.
   always_comb begin
      dec_d = '0;
      dec_d.valid = 1'b1;
      dec_d.bit_num = opcode[3:`BITNUM_LSB];
      case (opcode)
         `OP_BIT0_JMP_HI, `OP_BIT0_JMP_LO: begin
            dec_d.length = 2'd3;
            dec_d.cycles = 4'd5;
            dec_d.mode = opdec_pkg::mode_page_zero;
         end
         `OP_BIT0_SET, `OP_BIT0_CLR: begin
            dec_d.length = 2'd2;
            dec_d.cycles = 4'd5;
            dec_d.mode = opdec_pkg::mode_page_zero;
         end
         `OP_JMP_ALWAYS, `OP_JMP_NEVER: begin
            dec_d.length = 2'd2;
            dec_d.cycles = 4'd3;
            dec_d.mode = opdec_pkg::mode_relative;
         end
         `OP_CJE_DIR: begin
            dec_d.length = 2'd3;
            dec_d.cycles = 4'd5;
            dec_d.mode = opdec_pkg::mode_page_zero;
         end
         `OP_CJE_ACC, `OP_CJE_X: begin
            dec_d.length = 2'd3;
            dec_d.cycles = 4'd4;
            dec_d.mode = opdec_pkg::mode_literal;
         end
         `OP_CJE_IX1P: begin
            dec_d.length = 2'd3;
            dec_d.cycles = 4'd5;
            dec_d.mode = opdec_pkg::mode_byte_post_inc;
         end
         `OP_CJE_IXP: begin
            dec_d.length = 2'd2;
            dec_d.cycles = 4'd5;
            dec_d.mode = opdec_pkg::mode_post_inc;
         end
         `OP_NEG_DIR: begin
            dec_d.length = 2'd2;
            dec_d.cycles = 4'd5;
            dec_d.mode = opdec_pkg::mode_page_zero;
         end
         `OP_NEG_ACC, `OP_NEG_XL: begin
            dec_d.length = 2'd1;
            dec_d.cycles = 4'd1;
            dec_d.mode = opdec_pkg::mode_none;
         end
         `OP_NEG_IX1: begin
            dec_d.length = 2'd2;
            dec_d.cycles = 4'd5;
            dec_d.mode = opdec_pkg::mode_indexed_byte;
         end
         `OP_HALT_WAIT, `OP_X_TO_SP: begin
            dec_d.length = 2'd1;
            dec_d.cycles = 4'd2;
            dec_d.mode = opdec_pkg::mode_none;
         end
         `OP_CMP_DIR: begin
            dec_d.length = 2'd2;
            dec_d.cycles = 4'd3;
            dec_d.mode = opdec_pkg::mode_page_zero;
         end
         `OP_SUB_EXT, `OP_CMP_EXT: begin
            dec_d.length = 2'd3;
            dec_d.cycles = 4'd4;
            dec_d.mode = opdec_pkg::mode_full_address;
         end
         `OP_SUB_IX2, `OP_CMP_IX2: begin
            dec_d.length = 2'd3;
            dec_d.cycles = 4'd4;
            dec_d.mode = opdec_pkg::mode_indexed_word;
         end
         `OP_SUB_IX1, `OP_CMP_IX1: begin
            dec_d.length = 2'd2;
            dec_d.cycles = 4'd3;
            dec_d.mode = opdec_pkg::mode_indexed_byte;
         end
         `OP_SUB_IX, `OP_CMP_IX: begin
            dec_d.length = 2'd1;
            dec_d.cycles = 4'd3;
            dec_d.mode = opdec_pkg::mode_indexed_none;
         end
         default: begin
            dec_d.valid = 1'b0;
         end
      endcase
   end

   // Effective address, branch target, literal and vector address.
   always_comb begin
      off_ext = {8'h00, opnd_lo};
      lit_d = {opnd_hi, opnd_lo};
      br_d = pc_next + {{8{opnd_lo[7]}}, opnd_lo};
      vec_d = {`VEC_PAGE, vec_low};
      case (dec_d.mode)
         opdec_pkg::mode_page_zero: ea_d = {`ZERO_PAGE, opnd_lo};
         opdec_pkg::mode_full_address: ea_d = {opnd_hi, opnd_lo};
         opdec_pkg::mode_indexed_byte,
         opdec_pkg::mode_byte_post_inc: ea_d = index_pair + off_ext;
         opdec_pkg::mode_indexed_word: ea_d = index_pair + {opnd_hi, opnd_lo};
         opdec_pkg::mode_indexed_none,
         opdec_pkg::mode_post_inc: ea_d = index_pair;
         default: ea_d = pc_next;
      endcase
   end

   // Bus cycle kind; a pushed byte writes, and every other cycle reads.
   always_comb begin
      req_d.write = 1'b0;
      req_d.addr = pc_next;
      req_d.kind = opdec_pkg::cyc_fetch;
      if (push_req) begin
         req_d.write = 1'b1;
         req_d.addr = sp_in;
         req_d.kind = opdec_pkg::cyc_push;
      end else if (pop_req) begin
         req_d.addr = sp_in;
         req_d.kind = opdec_pkg::cyc_pop;
      end else if (vec_lo_phase) begin
         req_d.addr = vec_d;
         req_d.kind = opdec_pkg::cyc_vector;
      end else if (opcode == `OP_X_TO_SP || opcode == `OP_HALT_WAIT) begin
         // The first cycle of these is idle, yet still looks like a read.
         req_d.kind = opdec_pkg::cyc_free;
      end
   end

   // Stack pointer load, mask clear and halt tracking.
   always_comb begin
      sp_d = sp_q;
      sp_load_d = 1'b0;
      flags_d = flags_in;
      halt_d = halt_q;
      if (opcode == `OP_X_TO_SP) begin
         sp_d = index_pair - `ONE_16;
         sp_load_d = 1'b1;
      end
      if (opcode == `OP_HALT_WAIT && !halt_q) begin
         flags_d[`IRQ_MASK_BIT] = 1'b0;
         halt_d = 1'b1;
      end else if (halt_q && irq_pending) begin
         halt_d = 1'b0;
      end
   end

   always_ff @(posedge ref_clk or negedge rst_b) begin
      if (!rst_b) begin
         dec_q <= '0;
         req_q <= '0;
         sp_q <= '0;
         ea_q <= '0;
         br_q <= '0;
         lit_q <= '0;
         vec_q <= '0;
         flags_q <= '0;
         sp_load_q <= 1'b0;
         halt_q <= 1'b0;
      end else begin
         dec_q <= dec_d;
         req_q <= req_d;
         sp_q <= sp_d;
         ea_q <= ea_d;
         br_q <= br_d;
         lit_q <= lit_d;
         vec_q <= vec_d;
         flags_q <= flags_d;
         sp_load_q <= sp_load_d;
         halt_q <= halt_d;
      end
   end

   assign dec_out = dec_q;
   assign bus_req = req_q;
   assign sp_out = sp_q;
   assign sp_load = sp_load_q;
   assign flags_out = flags_q;
   assign halted = halt_q;
   assign ea_out = ea_q;
   assign branch_target = br_q;
   assign literal_word = lit_q;
   assign vec_addr = vec_q;

   sequence s_halt_req;
      opcode == `OP_HALT_WAIT && !halted;
   endsequence
   sequence s_halted_mask;
      halted && !flags_out[`IRQ_MASK_BIT];
   endsequence

   // Every check lives in the one clock domain, so they share clock and reset.
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (!rst_b);

   a_sp_transfer: assert property (
      opcode == `OP_X_TO_SP |=>
      sp_load && sp_out == $past(index_pair) - `ONE_16)
      else $error("stack pointer transfer wrong");
   a_sp_flags_kept: assert property (
      opcode == `OP_X_TO_SP |=> flags_out == $past(flags_in))
      else $error("flags changed by transfer");
   a_halt_entry: assert property (
      s_halt_req |=> s_halted_mask)
      else $error("halt entry wrong");
   a_halt_hold: assert property (
      halted && !irq_pending |=> halted)
      else $error("halt left without interrupt");
   a_free_read: assert property (
      req_q.kind == opdec_pkg::cyc_free |-> !req_q.write)
      else $error("free cycle not a read");
   a_page_zero: assert property (
      opcode == `OP_NEG_DIR |=> ea_out == {`ZERO_PAGE, $past(opnd_lo)})
      else $error("page zero high byte");
   a_byte_offset: assert property (
      opcode == `OP_SUB_IX1 |=>
      ea_out == $past(index_pair) + {`ZERO_PAGE, $past(opnd_lo)})
      else $error("offset not zero extended");
   a_branch_calc: assert property (
      1'b1 |=> branch_target ==
      $past(pc_next) + {{8{$past(opnd_lo[7])}}, $past(opnd_lo)})
      else $error("branch target wrong");
   a_cmp_ext: assert property (
      opcode == `OP_CMP_EXT |=> dec_q.valid && dec_q.length == 2'd3 &&
      dec_q.cycles == 4'd4 && dec_q.mode == opdec_pkg::mode_full_address)
      else $error("compare extended decode wrong");
endmodule

// [opdec_cfg.svh]
`ifndef OPDEC_CFG_SVH
`define OPDEC_CFG_SVH
// Opcodes handled by this decoder.
`define OP_BIT0_JMP_HI 8'h00
`define OP_BIT0_JMP_LO 8'h01
`define OP_BIT0_SET 8'h10
`define OP_BIT0_CLR 8'h11
`define OP_JMP_ALWAYS 8'h20
`define OP_JMP_NEVER 8'h21
`define OP_NEG_DIR 8'h30
`define OP_CJE_DIR 8'h31
`define OP_NEG_ACC 8'h40
`define OP_CJE_ACC 8'h41
`define OP_NEG_XL 8'h50
`define OP_CJE_X 8'h51
`define OP_NEG_IX1 8'h60
`define OP_CJE_IX1P 8'h61
`define OP_CJE_IXP 8'h71
`define OP_HALT_WAIT 8'h8F
`define OP_X_TO_SP 8'h94
`define OP_CMP_DIR 8'hB1
`define OP_SUB_EXT 8'hC0
`define OP_CMP_EXT 8'hC1
`define OP_SUB_IX2 8'hD0
`define OP_CMP_IX2 8'hD1
`define OP_SUB_IX1 8'hE0
`define OP_CMP_IX1 8'hE1
`define OP_SUB_IX 8'hF0
`define OP_CMP_IX 8'hF1
// Fixed address pieces and bit positions.
`define VEC_PAGE 8'hFF
`define ZERO_PAGE 8'h00
`define ONE_16 16'h0001
`define IRQ_MASK_BIT 3
`define BITNUM_LSB 1
`endif

// [opdec_pkg.sv]
package opdec_pkg;
   typedef enum logic [3:0] {
      mode_none, mode_literal, mode_page_zero, mode_full_address,
      mode_indexed_none, mode_indexed_byte, mode_indexed_word,
      mode_post_inc, mode_byte_post_inc, mode_relative
   } mode_type;
   typedef enum logic [2:0] {
      cyc_free, cyc_fetch, cyc_read, cyc_write, cyc_push, cyc_pop,
      cyc_vector
   } bus_cycle_type;
   typedef struct packed {
      logic valid;
      logic [1:0] length;
      logic [3:0] cycles;
      mode_type mode;
      logic [2:0] bit_num;
   } decode_type;
   typedef struct packed {
      logic [15:0] addr;
      logic write;
      bus_cycle_type kind;
   } bus_req_type;
endpackage

// [prog_mem_model.sv]
`timescale 1ns/1ps
// Program memory behind the decoder. Reads are combinational, so the
// opcode and the two bytes after it are settled before the sampling edge.
module prog_mem_model (
   input wire logic ref_clk,
   input wire logic [15:0] fetch_addr,
   input wire logic ld_en,
   input wire logic [7:0] ld_addr,
   input wire logic [7:0] ld_data,
   output logic [7:0] opcode,
   output logic [7:0] opnd_hi,
   output logic [7:0] opnd_lo
);
   logic [7:0] mem [256];
   // Start from zeros so that unloaded bytes never feed unknowns downstream.
   initial begin
      for (int i = 0; i < 256; i++) begin
         mem[i] = 8'h00;
      end
   end
   // The bench loads one byte per clock; only the low page is modelled.
   always @(posedge ref_clk) begin
      if (ld_en) begin
         mem[ld_addr] <= ld_data;
      end
   end
   // Operand bytes come from the locations that follow the opcode.
   assign opcode = mem[fetch_addr[7:0]];
   assign opnd_hi = mem[fetch_addr[7:0] + 8'h01];
   assign opnd_lo = mem[fetch_addr[7:0] + 8'h02];
endmodule

// [cpu_opcode_decode_subset_tb_top.sv]
`timescale 1ns/1ps
module cpu_opcode_decode_subset_tb_top;
   logic ref_clk, rst_b, ld_en, vec_lo_phase, push_req, pop_req;
   logic irq_pending, sp_load, halted;
   logic [15:0] fetch_addr, pc_next, index_pair, sp_in, sp_out, ea_out;
   logic [15:0] branch_target, literal_word, vec_addr;
   logic [7:0] opcode, opnd_hi, opnd_lo, flags_in, vec_low, ld_addr;
   logic [7:0] ld_data, flags_out;
   logic [13:0] dec_out;
   logic [19:0] bus_req;
   int n_mismatch, checked, cycles;
   // Entries are {opcode, length, cycles, mode}; the last one is unlisted.
   localparam logic [19:0] tbl [27] = '{
      20'h0_0352, 20'h0_1352, 20'h1_0252, 20'h1_1252, 20'h2_0239,
      20'h2_1239, 20'h3_0252, 20'h3_1352, 20'h4_0110, 20'h4_1341,
      20'h5_0110, 20'h5_1341, 20'h6_0255, 20'h6_1358, 20'h7_1257,
      20'h8_F120, 20'h9_4120, 20'hB_1232, 20'hC_0343, 20'hC_1343,
      20'hD_0346, 20'hD_1346, 20'hE_0235, 20'hE_1235, 20'hF_0134,
      20'hF_1134, 20'h0_2000};
   // Operand programs placed from address 40 upward.
   localparam logic [7:0] img [15] = '{8'h30, 8'h55, 8'h55, 8'h60, 8'hF0,
      8'hF0, 8'h20, 8'h80, 8'h80, 8'hC1, 8'h12, 8'h34, 8'h20, 8'h7F, 8'h7F};

   opdec i_opdec (.ref_clk(ref_clk), .rst_b(rst_b), .opcode(opcode),
      .opnd_hi(opnd_hi), .opnd_lo(opnd_lo), .pc_next(pc_next),
      .index_pair(index_pair), .sp_in(sp_in), .flags_in(flags_in),
      .vec_low(vec_low), .vec_lo_phase(vec_lo_phase), .push_req(push_req),
      .pop_req(pop_req), .irq_pending(irq_pending), .dec_out(dec_out),
      .sp_out(sp_out), .sp_load(sp_load), .flags_out(flags_out),
      .halted(halted), .ea_out(ea_out), .branch_target(branch_target),
      .literal_word(literal_word), .vec_addr(vec_addr), .bus_req(bus_req));
   prog_mem_model i_prog_mem_model (.ref_clk(ref_clk),
      .fetch_addr(fetch_addr), .ld_en(ld_en), .ld_addr(ld_addr),
      .ld_data(ld_data), .opcode(opcode), .opnd_hi(opnd_hi),
      .opnd_lo(opnd_lo));

   // Free-running clock at 25 ns.
   initial begin
      ref_clk = 1'b0;
      forever #12.5 ref_clk = ~ref_clk;
   end
   // A hang is cut short well after the expected run of about a hundred cycles.
   always @(posedge ref_clk) begin
      cycles++;
      if (cycles == 3000) begin
         n_mismatch++;
         end_sim();
      end
   end

   task automatic end_sim();
      if (n_mismatch == 0 && checked > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask
   task automatic chk(input string what, input logic [22:0] exp, got);
      checked++;
      if (got !== exp) begin
         n_mismatch++;
         $display("mismatch %s expected %h seen %h", what, exp, got);
      end
   endtask
   // Inputs change at the falling edge; results are read one cycle later.
   task automatic go(input logic [15:0] a);
      fetch_addr = a;
      @(negedge ref_clk);
   endtask
   task automatic put(input logic [7:0] a, input logic [7:0] d);
      ld_en = 1'b1;
      ld_addr = a;
      ld_data = d;
      @(negedge ref_clk);
   endtask

   task automatic decode_table();
      logic [19:0] e;
      for (int i = 0; i < 27; i++) begin
         e = tbl[i];
         go(16'(i));
         chk("dec", {(i < 26), e[9:8], e[7:4], e[3:0]}, dec_out[13:3]);
         if (i < 4) begin
            chk("bit_num", 23'h0, dec_out[2:0]);
         end
      end
   endtask
   task automatic operand_modes();
      index_pair = 16'h12FF;
      pc_next = 16'h0200;
      go(16'h0040);
      chk("ea_zero_page", 23'h0055, ea_out);
      go(16'h0043);
      chk("ea_byte_ofs", 23'h13EF, ea_out);
      go(16'h0046);
      chk("branch_back", 23'h0180, branch_target);
      go(16'h0049);
      chk("literal", 23'h1234, literal_word);
      go(16'h004C);
      chk("branch_fwd", 23'h027F, branch_target);
   endtask
   task automatic stack_xfer();
      flags_in = 8'hA5;
      index_pair = 16'h1000;
      go(16'd16);
      chk("sp_out", 23'h0FFF, sp_out);
      chk("sp_load", 23'h1, sp_load);
      chk("flags", 23'hA5, flags_out);
      chk("free_read", 23'h0, bus_req[3:0]);
      index_pair = 16'h0000;
      go(16'd16);
      chk("sp_borrow", 23'hFFFF, sp_out);
      go(16'd4);
      chk("sp_load_end", 23'h0, sp_load);
   endtask
   task automatic bus_cycles();
      sp_in = 16'h01F0;
      vec_low = 8'hFE;
      push_req = 1'b1;
      pop_req = 1'b1;
      go(16'd4);
      chk("push", {16'h01F0, 1'b1, 3'd4}, bus_req);
      chk("vector", 23'hFFFE, vec_addr);
      push_req = 1'b0;
      go(16'd4);
      chk("pop", {16'h01F0, 1'b0, 3'd5}, bus_req);
      pop_req = 1'b0;
      vec_lo_phase = 1'b1;
      go(16'd4);
      chk("vec_cycle", {16'hFFFE, 1'b0, 3'd6}, bus_req);
      vec_lo_phase = 1'b0;
   endtask
   task automatic halt_wait();
      irq_pending = 1'b0;
      flags_in = 8'hFF;
      go(16'd15);
      chk("halt", 23'h1, halted);
      chk("mask_clear", 23'hF7, flags_out);
      go(16'd4);
      go(16'd4);
      chk("halt_hold", 23'h1, halted);
      irq_pending = 1'b1;
      go(16'd4);
      chk("wake", 23'h0, halted);
   endtask

   // Main sequence: reset, load the programs, then run every scenario.
   initial begin
      {rst_b, ld_en, vec_lo_phase, push_req, pop_req} = '0;
      {fetch_addr, pc_next, index_pair, sp_in} = '0;
      {flags_in, vec_low, ld_addr, ld_data} = '0;
      irq_pending = 1'b1;
      repeat (10) @(negedge ref_clk);
      rst_b = 1'b1;
      for (int i = 0; i < 27; i++) put(8'(i), tbl[i][19:12]);
      for (int j = 0; j < 15; j++) put(8'h40 + 8'(j), img[j]);
      ld_en = 1'b0;
      decode_table();
      operand_modes();
      stack_xfer();
      bus_cycles();
      halt_wait();
      end_sim();
   end
endmodule
